/* rtl/lpsc_map.vh */
// Purpose: constants for the lcd power save control block
// Assumes: ahb-lite register bus, 32-bit words, byte addresses
// Notes:   register map, field positions, reset values and timing counts
`ifndef LPSC_MAP_VH
`define LPSC_MAP_VH

// ==========================================
// register offsets
`define LPSC_OFS_PSCFG     8'h14
`define LPSC_OFS_IRQ_STAT  8'h18
`define LPSC_OFS_IRQ_MASK  8'h1c
`define LPSC_OFS_SERIAL    8'h20

// ==========================================
// field positions and masks
`define LPSC_BIT_BIAS      0
`define LPSC_BIT_PSE       4
`define LPSC_BIT_MPS       6
`define LPSC_BIT_VBLANK    7
`define LPSC_PSCFG_WMASK   32'h00000011
`define LPSC_PSCFG_RST     32'h00000010
`define LPSC_IRQ_BITS      3

// ==========================================
// timing
`define LPSC_MEM_IDLE_CYC  8'h10
`define LPSC_MEM_WAKE_CYC  4'h4
`define LPSC_LINE_CYC      16'h0640

`endif

/* rtl/lpsc_mem_ctrl.v */
// Purpose: memory interface power state with wake for buffer writes
// Assumes: single clock, memory write and read requests are pulses
// Notes:   powers down after an idle period once power save is on
`timescale 1ns/10ps
`include "lpsc_map.vh"
module lpsc_mem_ctrl (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       power_save,
  input  wire       mem_wr_req,
  input  wire       mem_rd_req,
  output reg        mem_down,
  output reg        mem_wr_ack,
  output reg        mem_rd_ack,
  output reg        mem_rd_err
);
  reg [7:0] idle_cnt;
  reg [3:0] wake_cnt;
  reg       wr_pend;

  // ==========================================
  // power state
  // a write while down must wait for wake; the ack only comes once awake
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_down   <= 1'b0;
      idle_cnt   <= 8'h00;
      wake_cnt   <= 4'h0;
      wr_pend    <= 1'b0;
      mem_wr_ack <= 1'b0;
      mem_rd_ack <= 1'b0;
      mem_rd_err <= 1'b0;
    end else begin
      mem_wr_ack <= 1'b0;
      mem_rd_ack <= 1'b0;
      mem_rd_err <= 1'b0;
      if (mem_rd_req) begin
        if (power_save)
          mem_rd_err <= 1'b1;
        else
          mem_rd_ack <= 1'b1;
      end
      if (mem_wr_req)
        wr_pend <= 1'b1;
      if (!power_save) begin
        mem_down <= 1'b0;
        idle_cnt <= 8'h00;
        if (wr_pend || mem_wr_req) begin
          wr_pend    <= 1'b0;
          mem_wr_ack <= 1'b1;
        end
      end else if (wr_pend || mem_wr_req) begin
        if (mem_down) begin
          mem_down <= 1'b0;
          wake_cnt <= `LPSC_MEM_WAKE_CYC;
        end else if (wake_cnt != 4'h0) begin
          wake_cnt <= wake_cnt - 4'h1;
        end else begin
          wr_pend    <= 1'b0;
          mem_wr_ack <= 1'b1;
        end
        idle_cnt <= 8'h00;
      end else if (!mem_down) begin
        if (idle_cnt == `LPSC_MEM_IDLE_CYC)
          mem_down <= 1'b1;
        else
          idle_cnt <= idle_cnt + 8'h01;
      end
    end
  end
endmodule

/* rtl/lpsc_panel_drv.v */
// Purpose: panel output gating and vertical blank flag
// Assumes: panel data arrives on hclk
// Notes:   line counter is a stand-in frame timebase
`timescale 1ns/10ps
`include "lpsc_map.vh"
module lpsc_panel_drv #(
  parameter LINES = 240
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        power_save,
  input  wire [15:0] pix_data,
  output reg  [15:0] panel_data,
  output reg         panel_frame,
  output reg         vblank_pulse,
  output reg         vertical_blank_period_flag
);
  reg [15:0] cyc_cnt;
  reg [9:0]  line_cnt;

  // ==========================================
  // timebase and gating
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_cnt                    <= 16'h0000;
      line_cnt                   <= 10'h000;
      panel_data                 <= 16'h0000;
      panel_frame                <= 1'b0;
      vblank_pulse               <= 1'b0;
      vertical_blank_period_flag <= 1'b0;
    end else begin
      vblank_pulse <= 1'b0;
      if (power_save) begin
        panel_data                 <= 16'h0000;
        panel_frame                <= 1'b0;
        vertical_blank_period_flag <= 1'b0;
        cyc_cnt                    <= 16'h0000;
        line_cnt                   <= 10'h000;
      end else begin
        panel_data <= pix_data;
        if (cyc_cnt == `LPSC_LINE_CYC - 16'h0001) begin
          cyc_cnt <= 16'h0000;
          if (line_cnt == LINES[9:0] - 10'h001) begin
            line_cnt    <= 10'h000;
            panel_frame <= 1'b1;
          end else begin
            line_cnt    <= line_cnt + 10'h001;
            panel_frame <= 1'b0;
          end
          if (line_cnt == LINES[9:0] - 10'h002)
            vblank_pulse <= 1'b1;
          vertical_blank_period_flag <= (line_cnt >= LINES[9:0] - 10'h002);
        end else begin
          cyc_cnt <= cyc_cnt + 16'h0001;
        end
      end
    end
  end
endmodule

/* rtl/lpsc_top.v */
// Purpose: lcd power save control with ahb-lite register access
// Assumes: single clock hclk, host keeps the power sequencing order
// Notes:   bias output is a plain register bit, sequencing is software's job
`timescale 1ns/10ps
`include "lpsc_map.vh"
module lpsc_top (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        mem_wr_req,
  input  wire        mem_rd_req,
  input  wire [15:0] pix_data,
  output reg         mem_wr_ack,
  output reg         mem_rd_ack,
  output reg         mem_rd_err,
  output reg  [15:0] panel_data,
  output reg         panel_frame,
  output reg         bias_power_control_output,
  output reg         irq
);
  reg                        power_save;
  reg                        bias_bit;
  reg  [`LPSC_IRQ_BITS-1:0]  irq_stat;
  reg  [`LPSC_IRQ_BITS-1:0]  irq_mask;
  reg  [31:0]                serial_reg;
  reg                        dp_wr;
  reg  [7:0]                 dp_addr;
  reg                        mps_q;
  wire                       mem_down;
  wire                       wr_ack_i;
  wire                       rd_ack_i;
  wire                       rd_err_i;
  wire [15:0]                pdata_i;
  wire                       pframe_i;
  wire                       vblank_pulse;
  wire                       vblank_flag;
  wire                       ap_valid;
  wire                       rd_req;
  wire [31:0]                pscfg_rd;
  wire [`LPSC_IRQ_BITS-1:0]  events;

  function [31:0] pscfg_word;
    input en;
    input mps;
    input vb;
    input bias;
    begin
      pscfg_word = 32'h00000000;
      pscfg_word[`LPSC_BIT_PSE]    = en;
      pscfg_word[`LPSC_BIT_MPS]    = mps;
      pscfg_word[`LPSC_BIT_VBLANK] = vb;
      pscfg_word[`LPSC_BIT_BIAS]   = bias;
    end
  endfunction

  // ==========================================
  // submodules
  lpsc_mem_ctrl u_mem (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .power_save (power_save),
    .mem_wr_req (mem_wr_req),
    .mem_rd_req (mem_rd_req),
    .mem_down   (mem_down),
    .mem_wr_ack (wr_ack_i),
    .mem_rd_ack (rd_ack_i),
    .mem_rd_err (rd_err_i)
  );

  lpsc_panel_drv u_panel (
    .hclk                       (hclk),
    .hresetn                    (hresetn),
    .power_save                 (power_save),
    .pix_data                   (pix_data),
    .panel_data                 (pdata_i),
    .panel_frame                (pframe_i),
    .vblank_pulse               (vblank_pulse),
    .vertical_blank_period_flag (vblank_flag)
  );

  // ==========================================
  // bus decode
  assign ap_valid = hsel && hready && htrans[1];
  assign rd_req   = ap_valid && !hwrite;
  assign pscfg_rd = pscfg_word(power_save, mem_down, vblank_flag, bias_bit);
  // events: memory went down, memory woke, vertical blank start
  assign events   = {vblank_pulse, mps_q & ~mem_down, ~mps_q & mem_down};

  // ==========================================
  // registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_save <= 1'b1;
      bias_bit   <= 1'b0;
      irq_mask   <= {`LPSC_IRQ_BITS{1'b0}};
      serial_reg <= 32'h00000000;
      dp_wr      <= 1'b0;
      dp_addr    <= 8'h00;
    end else begin
      dp_wr   <= ap_valid && hwrite;
      dp_addr <= haddr;
      if (dp_wr) begin
        case (dp_addr)
          `LPSC_OFS_PSCFG: begin
            power_save <= hwdata[`LPSC_BIT_PSE];
            bias_bit   <= hwdata[`LPSC_BIT_BIAS];
          end
          `LPSC_OFS_IRQ_MASK: irq_mask <= hwdata[`LPSC_IRQ_BITS-1:0];
          `LPSC_OFS_SERIAL: begin
            if (!power_save)
              serial_reg <= hwdata;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================
  // read data and interrupt status
  // set wins over the read clear so no event is lost
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      irq_stat  <= {`LPSC_IRQ_BITS{1'b0}};
      irq       <= 1'b0;
      mps_q     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      mps_q     <= mem_down;
      if (rd_req && haddr == `LPSC_OFS_IRQ_STAT)
        irq_stat <= events;
      else
        irq_stat <= irq_stat | events;
      irq <= |((irq_stat | events) & irq_mask);
      if (rd_req) begin
        case (haddr)
          `LPSC_OFS_PSCFG:     hrdata <= pscfg_rd;
          `LPSC_OFS_IRQ_STAT:  hrdata <= {29'h0, irq_stat};
          `LPSC_OFS_IRQ_MASK:  hrdata <= {29'h0, irq_mask};
          `LPSC_OFS_SERIAL:    hrdata <= power_save ? 32'h00000000 : serial_reg;
          default:             hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================
  // registered outputs
  // bias follows software; the device does not time the discharge itself
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_wr_ack                <= 1'b0;
      mem_rd_ack                <= 1'b0;
      mem_rd_err                <= 1'b0;
      panel_data                <= 16'h0000;
      panel_frame               <= 1'b0;
      bias_power_control_output <= 1'b0;
    end else begin
      mem_wr_ack                <= wr_ack_i;
      mem_rd_ack                <= rd_ack_i;
      mem_rd_err                <= rd_err_i;
      panel_data                <= pdata_i;
      panel_frame               <= pframe_i;
      bias_power_control_output <= bias_bit;
    end
  end
endmodule

/* tb/lpsc_top_properties.sv */
// Purpose: port checker for lpsc_top
// Assumes: one clock, async low reset
// Notes:   ps shadows the enable bit from bus writes
`timescale 1ns/10ps
module lpsc_top_properties (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [7:0]  haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        mem_wr_req,
  input wire        mem_rd_req,
  input wire [15:0] pix_data,
  input wire        mem_wr_ack,
  input wire        mem_rd_ack,
  input wire        mem_rd_err,
  input wire [15:0] panel_data,
  input wire        panel_frame,
  input wire        bias_power_control_output,
  input wire        irq
);
  // ===
  // shadow of the config word
  reg       dv, dw, ps, bias;
  reg [7:0] da;
  reg [2:0] st;
  wire      wcfg = dv && dw && da == 8'h14;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dv   <= 1'b0;
      dw   <= 1'b0;
      da   <= 8'h00;
      ps   <= 1'b1;
      bias <= 1'b0;
      st   <= 3'd0;
    end else begin
      dv <= hsel && hready && htrans[1];
      da <= haddr;
      dw <= hwrite;
      ps <= wcfg ? hwdata[4] : ps;
      bias <= wcfg ? hwdata[0] : bias;
      // st: cycles since ps moved, saturating so the pipeline can settle
      st <= (wcfg && hwdata[4] != ps) ? 3'd0 : (st == 3'd7 ? st : st + 3'd1);
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ===
  // properties
  a_bus_okay:    assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_cfg_read:    assert property (dv && !dw && da == 8'h14 |->
    hrdata[31:8] == 0 && hrdata[5] == 0 && hrdata[3:1] == 0 && hrdata[4] == ps)
    else $error("config read wrong");
  a_unmap_zero:  assert property (dv && !dw && da == 8'h24 |-> hrdata == 0)
    else $error("unmapped read not zero");
  // the pin is one flop behind the bit, so compare with last cycle's shadow
  a_bias_follow: assert property (bias_power_control_output == $past(bias))
    else $error("bias pin not following bit 0");
  a_panel_quiet: assert property (ps && st > 3 |-> panel_data == 0 && !panel_frame)
    else $error("panel active in power save");
  a_panel_pass:  assert property (!ps && st > 3 |-> panel_data == $past(pix_data, 2))
    else $error("panel data not passed");
  a_rd_refused:  assert property (ps && st > 3 && mem_rd_req |->
    ##2 mem_rd_err && !mem_rd_ack)
    else $error("read served in power save");
  a_rd_served:   assert property (!ps && st == 7 && mem_rd_req |->
    ##2 mem_rd_ack && !mem_rd_err)
    else $error("read not served");
  a_wr_ack_soon: assert property (mem_wr_req |-> ##[2:40] mem_wr_ack)
    else $error("buffer write not acknowledged");
endmodule
bind lpsc_top lpsc_top_properties u_props (
  .hclk                      (hclk),
  .hresetn                   (hresetn),
  .hsel                      (hsel),
  .haddr                     (haddr),
  .htrans                    (htrans),
  .hwrite                    (hwrite),
  .hwdata                    (hwdata),
  .hready                    (hready),
  .hrdata                    (hrdata),
  .hreadyout                 (hreadyout),
  .hresp                     (hresp),
  .mem_wr_req                (mem_wr_req),
  .mem_rd_req                (mem_rd_req),
  .pix_data                  (pix_data),
  .mem_wr_ack                (mem_wr_ack),
  .mem_rd_ack                (mem_rd_ack),
  .mem_rd_err                (mem_rd_err),
  .panel_data                (panel_data),
  .panel_frame               (panel_frame),
  .bias_power_control_output (bias_power_control_output),
  .irq                       (irq)
);

/* tb/lpsc_bias_supply.sv */
// Purpose: panel bias supply model
// Assumes: linear ramp of RAMP cycles
// Notes:   slow on purpose so host waits are real
`timescale 1ns/10ps
module lpsc_bias_supply #(
  parameter RAMP = 30
) (
  input  wire hclk,
  input  wire bias_on,
  output wire drained
);
  integer lvl = 0;
  always @(posedge hclk) begin
    if (bias_on && lvl < RAMP)
      lvl <= lvl + 1;
    else if (!bias_on && lvl > 0)
      lvl <= lvl - 1;
  end
  // panel signals may only stop once this is high
  assign drained = (lvl == 0);
endmodule

/* tb/lcd_power_save_control_tb.sv */
// Purpose: self-checking bench for lpsc_top
// Assumes: zero wait state slave, host keeps power order
// Notes:   vblank bit masked, its timing is free running
`timescale 1ns/10ps
module lcd_power_save_control_tb;
  localparam RAMP = 30;
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         hsel = 1'b0;
  reg  [7:0]  haddr = 8'h00;
  reg  [1:0]  htrans = 2'b00;
  reg         hwrite = 1'b0;
  reg  [2:0]  hsize = 3'b010;
  reg  [31:0] hwdata = 32'h0;
  reg         mem_wr_req = 1'b0;
  reg         mem_rd_req = 1'b0;
  reg  [15:0] pix_data = 16'h0;
  reg         chk_pan = 1'b0;
  // pixel clock source: off at power-up, the panel path only moves while on
  reg         pix_on = 1'b0;
  reg  [31:0] rd;
  wire [31:0] hrdata;
  wire [15:0] panel_data;
  wire        hreadyout, hresp, mem_wr_ack, mem_rd_ack, mem_rd_err;
  wire        panel_frame, bias_power_control_output, irq, drained;
  wire        hready = hreadyout;
  integer     err_count = 0;
  integer     checked = 0;
  integer     m_ps, n, k;
  logic [15:0] pq[$];
  always #10 hclk = ~hclk;
  lpsc_top dut (
    .hclk                      (hclk),
    .hresetn                   (hresetn),
    .hsel                      (hsel),
    .haddr                     (haddr),
    .htrans                    (htrans),
    .hwrite                    (hwrite),
    .hsize                     (hsize),
    .hwdata                    (hwdata),
    .hready                    (hready),
    .hrdata                    (hrdata),
    .hreadyout                 (hreadyout),
    .hresp                     (hresp),
    .mem_wr_req                (mem_wr_req),
    .mem_rd_req                (mem_rd_req),
    .pix_data                  (pix_data),
    .mem_wr_ack                (mem_wr_ack),
    .mem_rd_ack                (mem_rd_ack),
    .mem_rd_err                (mem_rd_err),
    .panel_data                (panel_data),
    .panel_frame               (panel_frame),
    .bias_power_control_output (bias_power_control_output),
    .irq                       (irq)
  );
  lpsc_bias_supply #(.RAMP(RAMP)) u_bias (.hclk(hclk), .bias_on(bias_power_control_output),
                                          .drained(drained));
  task check(input [31:0] seen, input [31:0] exp, input [8*10-1:0] what);
    checked = checked + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // a used-up bound is a mismatch and ends the run
  task limit(input integer cnt, input integer lim);
    if (cnt >= lim) begin
      err_count = err_count + 1;
      give_verdict;
    end
  endtask
  task wait_rdy;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge hclk);
      n = n + 1;
    end
    limit(n, 50);
  endtask
  // ===
  // bus cycle: address phase, then data phase
  task bus(input w, input [7:0] a, input [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  // exp is {refused, acknowledged}
  task mem(input wr, input [1:0] exp);
    if (wr)
      mem_wr_req <= 1'b1;
    else
      mem_rd_req <= 1'b1;
    @(posedge hclk);
    mem_wr_req <= 1'b0;
    mem_rd_req <= 1'b0;
    n = 0;
    while (!(mem_wr_ack | mem_rd_ack | mem_rd_err) && n < 60) begin
      @(posedge hclk);
      n = n + 1;
    end
    check({mem_rd_err, mem_rd_ack | mem_wr_ack}, exp, "mem");
    limit(n, 60);
  endtask
  always @(posedge hclk) begin
    if (pix_on)
      pix_data <= 16'($urandom);
    if (chk_pan && pq.size() == 2)
      check({16'h0, panel_data}, {16'h0, m_ps ? 16'h0 : pq[0]}, "panel");
    pq.push_back(pix_data);
    if (pq.size() > 2)
      void'(pq.pop_front());
  end
  task pan_window;
    chk_pan <= 1'b1;
    repeat (8) @(posedge hclk);
    chk_pan <= 1'b0;
  endtask
  initial begin
    void'($urandom(32'h60fc));
    m_ps = 1;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, 8'h14, 0);
    check(rd & 32'hffffff7f, 32'h10, "cfg_rst");
    repeat (40) @(posedge hclk);
    bus(0, 8'h14, 0);
    check(rd & 32'hffffff7f, 32'h50, "mem_down");
    check(irq, 0, "irq_mask");
    bus(1, 8'h1c, 1);
    bus(0, 8'h1c, 0);
    check(rd, 1, "mask");
    check(irq, 1, "irq_set");
    bus(0, 8'h18, 0);
    check(rd & 3, 1, "stat");
    bus(0, 8'h18, 0);
    check(rd & 3, 0, "stat_clr");
    check(irq, 0, "irq_clr");
    $display("test entry state done");
    mem(1, 1);
    mem(0, 2);
    bus(1, 8'h20, 32'ha5a5a5a5);
    bus(0, 8'h20, 0);
    check(rd, 0, "ser_ps");
    bus(1, 8'h24, 32'hffffffff);
    bus(0, 8'h24, 0);
    check(rd, 0, "unmap");
    $display("test power save access done");
    // memory clock is never stopped in this bench, nothing to restart
    pix_on <= 1'b1;
    bus(1, 8'h14, 0);
    m_ps = 0;
    repeat (RAMP) @(posedge hclk);
    bus(1, 8'h14, 32'hffffffef);
    bus(0, 8'h14, 0);
    check(rd & 32'hffffff7f, 1, "cfg_exit");
    mem(0, 1);
    mem(1, 1);
    bus(1, 8'h20, 32'h5a5a5a5a);
    bus(0, 8'h20, 0);
    check(rd, 32'h5a5a5a5a, "ser");
    pan_window;
    $display("test exit done");
    bus(1, 8'h14, 0);
    n = 0;
    while (!drained && n < 100) begin
      @(posedge hclk);
      n = n + 1;
    end
    check(drained, 1, "drained");
    limit(n, 100);
    bus(1, 8'h14, 32'h10);
    m_ps = 1;
    pix_on <= 1'b0;
    repeat (6) @(posedge hclk);
    pan_window;
    // memory clock may only stop once the status bit shows the interface down
    k = 0;
    rd = 0;
    while (rd[6] !== 1'b1 && k < 40) begin
      bus(0, 8'h14, 0);
      k = k + 1;
    end
    check(rd[6], 1, "mps_poll");
    limit(k, 40);
    bus(0, 8'h14, 0);
    check(rd & 32'hffffff3f, 32'h10, "cfg_ps");
    $display("test reentry done");
    give_verdict;
  end
endmodule
